/* File: design/rcs_delay_counter.sv */
// rcs_delay_counter: loadable down counter that ends a reset delay
// assumes start_i only while idle, as abort_i wins over start_i; tick_i is a same-clock enable
`timescale 1ns/100ps
`default_nettype none
module rcs_delay_counter #(
	parameter int unsigned CNT_W = 32
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic tick_i,
	input wire logic [CNT_W-1:0] len_i,
	output logic busy_o,
	output logic done_o
);
	logic [CNT_W-1:0] cnt_q;
	logic busy_q;
	wire last_w = (cnt_q == CNT_W'(1));

	assign done_o = busy_q & tick_i & last_w & ~abort_i;
	assign busy_o = busy_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
		end else if (abort_i) begin
			busy_q <= 1'b0;
		end else if (start_i) begin
			cnt_q <= len_i;
			busy_q <= 1'b1;
		end else if (busy_q && tick_i) begin
			cnt_q <= cnt_q - CNT_W'(1);
			busy_q <= ~last_w;
		end
	end
endmodule // rcs_delay_counter
`default_nettype wire

/* File: design/rcs_pkg.sv */
// rcs_pkg: constants, register map and types of the reset-cause sequencer
// assumes a 100 MHz core clock and 8-bit registers on a 32-bit register bus
package rcs_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned OSC_STARTUP_TICKS = 1024;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned PC_W = 13;

	localparam logic [7:0] ADDR_PWR_STAT = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CFG = 8'h08;
	localparam logic [7:0] ADDR_OPTION = 8'h0c;
	localparam logic [7:0] ADDR_DIR_A = 8'h10;
	localparam logic [7:0] ADDR_DIR_B = 8'h14;
	localparam logic [7:0] ADDR_IRQ = 8'h18;
	localparam logic [7:0] ADDR_PORTB = 8'h1c;
	localparam logic [7:0] ADDR_PERIOD = 8'h20;
	localparam logic [7:0] ADDR_WORK = 8'h24;
	localparam logic [7:0] ADDR_SEQ = 8'h28;

	localparam int unsigned PWR_OSC_BIT = 3;
	localparam int unsigned PWR_POR_BIT = 1;
	localparam int unsigned PWR_BRN_BIT = 0;
	localparam int unsigned STATUS_TMO_BIT = 4;
	localparam int unsigned STATUS_DOWN_BIT = 3;
	localparam int unsigned IRQ_GIE_BIT = 7;

	localparam logic [7:0] PWR_POR_VAL = 8'h09;
	localparam logic [7:0] PWR_WMASK = 8'h0b;
	localparam logic [7:0] PWR_BRN_CLR = 8'hfe;
	localparam logic [7:0] PWR_OSC_SET = 8'h08;
	localparam logic [7:0] STATUS_POR_VAL = 8'h18;
	localparam logic [7:0] STATUS_WMASK = 8'he7;
	localparam logic [7:0] ST_KEEP_LO = 8'h07;
	localparam logic [7:0] ST_KEEP_NO_TOP = 8'h1f;
	localparam logic [7:0] ST_KEEP_HI_LO = 8'he7;
	localparam logic [7:0] ST_TMO_DOWN = 8'h18;
	localparam logic [7:0] ST_TMO = 8'h10;
	localparam logic [7:0] ST_DOWN = 8'h08;
	localparam logic [7:0] FILL_ONES = 8'hff;
	localparam logic [7:0] IRQ_KEEP = 8'h01;
	localparam logic [7:0] PORTB_KEEP = 8'hfc;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h12;

	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_IRQ_VECTOR = 13'h0004;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		OSC_LOWPWR_XTAL, OSC_XTAL, OSC_FAST_XTAL, OSC_EXT_CLK, OSC_EXT_RES, OSC_INT_RC
	} rcs_osc_mode_t;

	typedef struct packed {
		logic [2:0] spare;
		logic bo_en;
		rcs_osc_mode_t mode;
		logic delay_en_n;
	} rcs_cfg_t;

	typedef enum logic [2:0] {
		ST_POR, ST_RUN, ST_SLEEP, ST_HOLD, ST_PUP_DELAY, ST_OSC_START
	} rcs_state_t;
endpackage

/* File: design/rcs_reset_ctrl.sv */
// rcs_reset_ctrl: reset-cause flags, start-up delays and register init
// assumes rst_n_i is the power-on pulse; pin and detector inputs are async
`timescale 1ns/100ps
`default_nettype none
module rcs_reset_ctrl
	import rcs_pkg::*;
#(
	parameter int unsigned POWERUP_DELAY_NS = 1000000,
	parameter int unsigned POWERUP_CYCLES = (POWERUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic external_reset_pin_n_i,
	input wire logic brownout_detect_i,
	input wire logic watchdog_timeout_i,
	input wire logic sleep_enter_i,
	input wire logic irq_wake_i,
	input wire logic osc_tick_i,
	input wire logic [PC_W-1:0] pc_i,
	output logic core_reset_o,
	output logic wake_hold_o,
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_value_o,
	output logic osc_speed_select_o,
	output logic [7:0] option_o,
	output logic [7:0] port_a_direction_o,
	output logic [7:0] port_b_direction_o,
	output logic [7:0] irq_control_o,
	output logic [7:0] port_b_out_o,
	output logic [7:0] timer_period_o
);
	// async pin and detector: three stages, change taken when last two agree
	logic [1:0] s1_q, s2_q, s3_q, filt_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 2'b01;
			s2_q <= 2'b01;
			s3_q <= 2'b01;
			filt_q <= 2'b01;
		end else begin
			s1_q <= {brownout_detect_i, external_reset_pin_n_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
		end
	end

	rcs_state_t state_q, state_d;
	rcs_cfg_t cfg_q;
	logic [7:0] pwrst_q, status_q, option_q, dir_a_q, dir_b_q, irq_q, portb_q, period_q, work_q;
	logic asleep_q, waking_q, pwr_type_q, core_reset_q, wake_hold_q, pc_load_q;
	logic [PC_W-1:0] pc_target_q;
	logic pud_done, osc_done;

	wire live = (state_q != ST_POR);
	wire in_run = (state_q == ST_RUN);
	wire in_sleep = (state_q == ST_SLEEP);
	wire bo_evt = filt_q[1] & cfg_q.bo_en & live;
	wire pin_evt = ~filt_q[0] & live;
	wire hold_evt = bo_evt | pin_evt;
	wire wdog_rst = watchdog_timeout_i & in_run & ~hold_evt;
	wire wdog_wake = watchdog_timeout_i & in_sleep & ~hold_evt;
	wire irq_wake = irq_wake_i & in_sleep & ~hold_evt & ~watchdog_timeout_i;
	wire sleep_go = sleep_enter_i & in_run & ~hold_evt & ~watchdog_timeout_i;
	wire ctrl_rst = hold_evt | wdog_rst;
	wire wake_evt = wdog_wake | irq_wake;
	wire xtal = (cfg_q.mode == OSC_LOWPWR_XTAL) | (cfg_q.mode == OSC_XTAL) |
		(cfg_q.mode == OSC_FAST_XTAL);
	wire irq_glob_en = irq_q[IRQ_GIE_BIT];

	// status next value per cause, hardware wins over a software write
	wire [7:0] st_bo = (status_q & ST_KEEP_LO) | ST_TMO_DOWN;
	wire [7:0] st_pin = asleep_q ? ((status_q & ST_KEEP_LO) | ST_TMO) : (status_q & ST_KEEP_NO_TOP);
	wire [7:0] st_wdog = (status_q & ST_KEEP_LO) | ST_DOWN;
	wire [7:0] st_wwk = status_q & ST_KEEP_HI_LO;
	wire [7:0] st_iwk = (status_q & ST_KEEP_HI_LO) | ST_TMO;
	wire [7:0] st_hw = bo_evt ? st_bo : pin_evt ? st_pin : wdog_rst ? st_wdog :
		wdog_wake ? st_wwk : st_iwk;
	wire st_hw_en = ctrl_rst | wake_evt | sleep_go;
	wire [PC_W-1:0] pc_wake = (irq_wake & irq_glob_en) ? PC_IRQ_VECTOR : (pc_i + PC_STEP);

	// sequencer: which delays follow which cause
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_POR:
				if (!cfg_q.delay_en_n) state_d = ST_PUP_DELAY;
				else if (xtal) state_d = ST_OSC_START;
				else state_d = ST_RUN;
			ST_RUN:
				if (wdog_rst) state_d = ST_HOLD;
				else if (sleep_go) state_d = ST_SLEEP;
			ST_SLEEP:
				if (wake_evt) state_d = xtal ? ST_OSC_START : ST_RUN;
			ST_HOLD:
				if (!hold_evt) state_d = pwr_type_q ? ST_PUP_DELAY : ST_RUN;
			ST_PUP_DELAY:
				if (pud_done) state_d = xtal ? ST_OSC_START : ST_RUN;
			ST_OSC_START:
				if (osc_done) state_d = ST_RUN;
		endcase
		if (hold_evt) state_d = ST_HOLD;
	end

	wire pud_start = (state_d == ST_PUP_DELAY) & (state_q != ST_PUP_DELAY);
	wire osc_start = (state_d == ST_OSC_START) & (state_q != ST_OSC_START);
	wire waking_d = (waking_q | wake_evt) & ~hold_evt & (state_d != ST_RUN);
	wire reset_d = (state_d != ST_RUN) & (state_d != ST_SLEEP) & ~waking_d;

	rcs_delay_counter #(.CNT_W(32)) u_powerup_delay_timer (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(pud_start), .abort_i(hold_evt),
		.tick_i(1'b1), .len_i(32'(POWERUP_CYCLES)), .busy_o(), .done_o(pud_done)
	);
	// ticks come from the oscillator input, so a stopped crystal stays in reset or, after a wake, in wake hold
	rcs_delay_counter #(.CNT_W(11)) u_osc_startup_counter (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(osc_start), .abort_i(hold_evt),
		.tick_i(osc_tick_i), .len_i(11'(OSC_STARTUP_TICKS)), .busy_o(), .done_o(osc_done)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_POR;
			asleep_q <= 1'b0;
			waking_q <= 1'b0;
			pwr_type_q <= 1'b0;
			core_reset_q <= 1'b1;
			wake_hold_q <= 1'b0;
			pc_load_q <= 1'b0;
			pc_target_q <= PC_RESET;
		end else begin
			state_q <= state_d;
			asleep_q <= (asleep_q | sleep_go) & ~wake_evt & ~((state_q == ST_HOLD) & ~hold_evt);
			waking_q <= waking_d;
			pwr_type_q <= (pwr_type_q | bo_evt) & ~((state_q == ST_HOLD) & ~hold_evt);
			core_reset_q <= reset_d;
			wake_hold_q <= waking_d;
			pc_load_q <= (state_d == ST_RUN) & (state_q != ST_RUN);
			if (ctrl_rst) pc_target_q <= PC_RESET;
			else if (wake_evt) pc_target_q <= pc_wake;
		end
	end

	// register bus: write address and data taken together, one answer pending
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] rdata_q;
	wire wr_fire = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
	wire rd_fire = s_axi_arvalid_i & ~rvalid_q;
	wire [7:0] wd = s_axi_wdata_i[7:0];
	wire wr_en = wr_fire & s_axi_wstrb_i[0];
	wire w_pwrst = wr_en & (s_axi_awaddr_i == ADDR_PWR_STAT);
	wire w_status = wr_en & (s_axi_awaddr_i == ADDR_STATUS);
	wire w_cfg = wr_en & (s_axi_awaddr_i == ADDR_CFG);
	wire w_option = wr_en & (s_axi_awaddr_i == ADDR_OPTION);
	wire w_dir_a = wr_en & (s_axi_awaddr_i == ADDR_DIR_A);
	wire w_dir_b = wr_en & (s_axi_awaddr_i == ADDR_DIR_B);
	wire w_irq = wr_en & (s_axi_awaddr_i == ADDR_IRQ);
	wire w_portb = wr_en & (s_axi_awaddr_i == ADDR_PORTB);
	wire w_period = wr_en & (s_axi_awaddr_i == ADDR_PERIOD);
	wire w_work = wr_en & (s_axi_awaddr_i == ADDR_WORK);
	wire aw_map = (s_axi_awaddr_i <= ADDR_SEQ) & (s_axi_awaddr_i[1:0] == 2'b00);
	wire ar_map = (s_axi_araddr_i <= ADDR_SEQ) & (s_axi_araddr_i[1:0] == 2'b00);
	wire [7:0] seq_view = {asleep_q, waking_q, core_reset_q, pwr_type_q, 1'b0, state_q};
	wire [7:0] rd_mux =
		(s_axi_araddr_i == ADDR_PWR_STAT) ? pwrst_q : (s_axi_araddr_i == ADDR_STATUS) ? status_q :
		(s_axi_araddr_i == ADDR_CFG) ? cfg_q : (s_axi_araddr_i == ADDR_OPTION) ? option_q :
		(s_axi_araddr_i == ADDR_DIR_A) ? dir_a_q : (s_axi_araddr_i == ADDR_DIR_B) ? dir_b_q :
		(s_axi_araddr_i == ADDR_IRQ) ? irq_q : (s_axi_araddr_i == ADDR_PORTB) ? portb_q :
		(s_axi_araddr_i == ADDR_PERIOD) ? period_q : (s_axi_araddr_i == ADDR_WORK) ? work_q :
		(s_axi_araddr_i == ADDR_SEQ) ? seq_view : ZERO8;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= ZERO8;
		end else begin
			if (wr_fire) bvalid_q <= 1'b1;
			else if (s_axi_bready_i) bvalid_q <= 1'b0;
			if (wr_fire) bresp_q <= aw_map ? RESP_OKAY : RESP_SLVERR;
			if (rd_fire) rvalid_q <= 1'b1;
			else if (s_axi_rready_i) rvalid_q <= 1'b0;
			if (rd_fire) rresp_q <= ar_map ? RESP_OKAY : RESP_SLVERR;
			if (rd_fire) rdata_q <= rd_mux;
		end
	end

	// cause flags and control registers; power-on is the async reset itself
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwrst_q <= PWR_POR_VAL;
			status_q <= STATUS_POR_VAL;
			cfg_q <= CFG_RST;
		end else begin
			if (bo_evt) pwrst_q <= (pwrst_q & PWR_BRN_CLR) | PWR_OSC_SET;
			else if (ctrl_rst) pwrst_q <= pwrst_q | PWR_OSC_SET;
			else if (w_pwrst) pwrst_q <= wd & PWR_WMASK;
			if (st_hw_en) status_q <= st_hw;
			else if (w_status) status_q <= (wd & STATUS_WMASK) | (status_q & ~STATUS_WMASK);
			if (w_cfg) cfg_q <= wd;
		end
	end

	// data-holding work register survives every reset but power-on
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			option_q <= FILL_ONES;
			dir_a_q <= FILL_ONES;
			dir_b_q <= FILL_ONES;
			irq_q <= ZERO8;
			portb_q <= ZERO8;
			period_q <= FILL_ONES;
			work_q <= ZERO8;
		end else begin
			option_q <= ctrl_rst ? FILL_ONES : w_option ? wd : option_q;
			dir_a_q <= ctrl_rst ? FILL_ONES : w_dir_a ? wd : dir_a_q;
			dir_b_q <= ctrl_rst ? FILL_ONES : w_dir_b ? wd : dir_b_q;
			irq_q <= ctrl_rst ? (irq_q & IRQ_KEEP) : w_irq ? wd : irq_q;
			portb_q <= (ctrl_rst | wake_evt) ? (portb_q & PORTB_KEEP) : w_portb ? wd : portb_q;
			period_q <= (ctrl_rst | wake_evt) ? FILL_ONES : w_period ? wd : period_q;
			if (w_work && !ctrl_rst) work_q <= wd;
		end
	end

	assign s_axi_awready_o = wr_fire;
	assign s_axi_wready_o = wr_fire;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = ~rvalid_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rresp_o = rresp_q;
	assign s_axi_rdata_o = {24'h000000, rdata_q};
	assign core_reset_o = core_reset_q;
	assign wake_hold_o = wake_hold_q;
	assign pc_load_o = pc_load_q;
	assign pc_value_o = pc_target_q;
	assign osc_speed_select_o = pwrst_q[PWR_OSC_BIT];
	assign option_o = option_q;
	assign port_a_direction_o = dir_a_q;
	assign port_b_direction_o = dir_b_q;
	assign irq_control_o = irq_q;
	assign port_b_out_o = portb_q;
	assign timer_period_o = period_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	por_flag_keep_a: assert property (ctrl_rst |=> pwrst_q[PWR_POR_BIT] == $past(pwrst_q[PWR_POR_BIT]))
		else $error("power-on flag changed by a later reset");
	brown_clear_a: assert property (bo_evt |=> !pwrst_q[PWR_BRN_BIT] && status_q[4:3] == 2'b11)
		else $error("brown-out did not clear its flag");
	osc_xtal_a: assert property ((state_q != ST_OSC_START && state_d == ST_OSC_START) |-> xtal)
		else $error("start-up count outside crystal modes");
	bo_delay_a: assert property ((state_q == ST_HOLD && !hold_evt && pwr_type_q) |=> state_q == ST_PUP_DELAY)
		else $error("brown-out release skipped power-up delay");
	wdog_wake_a: assert property (wdog_wake |=> status_q[4:3] == 2'b00 ##1 pc_value_o == $past(pc_i, 2) + PC_STEP)
		else $error("watchdog wake pattern wrong");
	irq_vector_a: assert property ((irq_wake && irq_glob_en) |=> status_q[4:3] == 2'b10 && pc_value_o == PC_IRQ_VECTOR)
		else $error("interrupt wake did not vector");
	ctrl_init_a: assert property (ctrl_rst |=> option_q == FILL_ONES && dir_b_q == FILL_ONES && irq_q[7:1] == 7'h00 && pwrst_q[PWR_OSC_BIT])
		else $error("control registers not initialised");
	wake_keep_a: assert property (wake_evt |=> period_q == FILL_ONES && portb_q[1:0] == 2'b00 && $stable(option_q) && !core_reset_o)
		else $error("wake changed ordinary registers");
	release_one_a: assert property ((state_q == ST_OSC_START && osc_done && !waking_q && !hold_evt) |=> !core_reset_o && pc_load_o && pc_value_o == PC_RESET)
		else $error("reset not released after start-up count");
endmodule // rcs_reset_ctrl
`default_nettype wire

/* File: verification/test_reset_cause_and_timeout_control.sv */
// test_reset_cause_and_timeout_control: self-checking bench of rcs_reset_ctrl
// assumes rcs_pkg compiled first; power-up delay shortened to 20 cycles
`timescale 1ns/100ps
`default_nettype none
module test_reset_cause_and_timeout_control
	import rcs_pkg::*;
();
	localparam int PW = 20;
	// osc_tick_i comes every other cycle, so the start-up count spans twice as many cycles as ticks
	localparam int OSC2 = 2 * OSC_STARTUP_TICKS;
	logic clk_i, rst_n_i;
	logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
	logic [3:0] s_axi_wstrb_i;
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp;
	logic external_reset_pin_n_i, brownout_detect_i, watchdog_timeout_i, sleep_enter_i;
	logic irq_wake_i, core_reset_o, wake_hold_o, pc_load_o, osc_speed_select_o;
	logic osc_tick_i = 1'b0;
	logic [PC_W-1:0] pc_i, pc_value_o, pcv;
	logic [7:0] option_o, port_a_direction_o, port_b_direction_o, irq_control_o;
	logic [7:0] port_b_out_o, timer_period_o;
	int bad_count = 0;
	int compares = 0;
	int n;
	int wk;
	// rows: address, expected read data, expected response
	logic [17:0] rows [9] = '{{ADDR_PWR_STAT, 8'h09, 2'h0}, {ADDR_STATUS, 8'h18, 2'h0},
		{ADDR_OPTION, 8'hff, 2'h0}, {ADDR_DIR_A, 8'hff, 2'h0}, {ADDR_DIR_B, 8'hff, 2'h0},
		{ADDR_IRQ, 8'h00, 2'h0}, {ADDR_PORTB, 8'h00, 2'h0}, {ADDR_PERIOD, 8'hff, 2'h0},
		{8'h2c, 8'h00, 2'h2}};
	logic [15:0] wrows [8] = '{{ADDR_PWR_STAT, 8'h03}, {ADDR_STATUS, 8'he5}, {ADDR_OPTION, 8'h00},
		{ADDR_DIR_A, 8'h00}, {ADDR_IRQ, 8'h81}, {ADDR_PORTB, 8'hff}, {ADDR_PERIOD, 8'h10},
		{ADDR_WORK, 8'h5a}};

	rcs_reset_ctrl #(.POWERUP_DELAY_NS(200)) DUT (
		.clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
		.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
		.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .external_reset_pin_n_i,
		.brownout_detect_i, .watchdog_timeout_i, .sleep_enter_i, .irq_wake_i, .osc_tick_i,
		.pc_i, .core_reset_o, .wake_hold_o, .pc_load_o, .pc_value_o, .osc_speed_select_o,
		.option_o, .port_a_direction_o, .port_b_direction_o, .irq_control_o, .port_b_out_o,
		.timer_period_o
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		osc_tick_i <= ~osc_tick_i;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic inr(input int v, input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction

	task automatic tick();
		@(negedge clk_i);
		wk++;
	endtask

	// ready is sampled at the falling edge; inputs only move after rising edges
	task automatic axw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= {24'h000000, d};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		wk = 0;
		do tick(); while (s_axi_awready_o !== 1'b1 && wk < 100);
		@(posedge clk_i);
		s_axi_awvalid_i <= 1'b0;
		s_axi_wvalid_i <= 1'b0;
		do tick(); while (s_axi_bvalid_o !== 1'b1 && wk < 200);
		rsp = s_axi_bresp_o;
		@(posedge clk_i);
		s_axi_bready_i <= 1'b0;
		if (wk >= 200) bad_count++;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		wk = 0;
		do tick(); while (s_axi_arready_o !== 1'b1 && wk < 100);
		@(posedge clk_i);
		s_axi_arvalid_i <= 1'b0;
		do tick(); while (s_axi_rvalid_o !== 1'b1 && wk < 200);
		rd = s_axi_rdata_o;
		rsp = s_axi_rresp_o;
		@(posedge clk_i);
		s_axi_rready_i <= 1'b0;
		if (wk >= 200) bad_count++;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		axr(a);
		chk($sformatf("register %h", a), rd, {24'h000000, e});
	endtask

	task automatic pulse(input int k);
		@(posedge clk_i);
		watchdog_timeout_i <= (k == 0);
		sleep_enter_i <= (k == 1);
		irq_wake_i <= (k == 2);
		@(posedge clk_i);
		watchdog_timeout_i <= 1'b0;
		sleep_enter_i <= 1'b0;
		irq_wake_i <= 1'b0;
	endtask

	// cycles until the core is let go, counted at falling edges
	task automatic wait_rel();
		wk = 0;
		do tick(); while (pc_load_o !== 1'b1 && wk < 6000);
		n = wk;
		pcv = pc_value_o;
		chk("core reset at load", core_reset_o, 0);
		if (wk >= 6000) bad_count++;
	endtask

	task automatic ext_rst(input logic bo);
		@(posedge clk_i);
		external_reset_pin_n_i <= bo;
		brownout_detect_i <= bo;
		repeat (8) @(posedge clk_i);
		external_reset_pin_n_i <= 1'b1;
		brownout_detect_i <= 1'b0;
		wait_rel();
	endtask

	initial begin
		repeat (40000) @(posedge clk_i);
		bad_count++;
		$display("wrong value run end expected done seen hang");
		summarize();
	end

	initial begin
		rst_n_i = 1'b0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
		{brownout_detect_i, watchdog_timeout_i, sleep_enter_i, irq_wake_i} = '0;
		s_axi_wstrb_i = 4'h1;
		external_reset_pin_n_i = 1'b1;
		pc_i = 13'h0123;
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		wait_rel();
		chk("power-on hold", inr(n, PW + OSC2 - 4, PW + OSC2 + 12), 1);
		chk("power-on pc", pcv, 13'h0000);
		for (int i = 0; i < 9; i++) begin
			axr(rows[i][17:10]);
			chk("power-on read", rd, {24'h000000, rows[i][9:2]});
			chk("read response", rsp, rows[i][1:0]);
		end
		for (int i = 0; i < 8; i++) begin
			axw(wrows[i][15:8], wrows[i][7:0]);
			chk("write response", rsp, 2'h0);
		end
		chk("slow oscillator", osc_speed_select_o, 0);
		$display("test power-on done");
		pulse(0);
		wait_rel();
		chk("watchdog hold", inr(n, 1, 3), 1);
		chk("watchdog pc", pcv, 13'h0000);
		chk("fast oscillator", osc_speed_select_o, 1);
		chk("option out", option_o, 8'hff);
		chk("port a dir out", port_a_direction_o, 8'hff);
		chk("port b dir out", port_b_direction_o, 8'hff);
		chk("irq control out", irq_control_o, 8'h01);
		chk("port b out", port_b_out_o, 8'hfc);
		chk("period out", timer_period_o, 8'hff);
		rc(ADDR_PWR_STAT, 8'h0b);
		rc(ADDR_STATUS, 8'h0d);
		rc(ADDR_OPTION, 8'hff);
		rc(ADDR_DIR_A, 8'hff);
		rc(ADDR_IRQ, 8'h01);
		rc(ADDR_PORTB, 8'hfc);
		rc(ADDR_PERIOD, 8'hff);
		rc(ADDR_WORK, 8'h5a);
		$display("test watchdog reset done");
		axw(ADDR_STATUS, 8'he5);
		axw(ADDR_PWR_STAT, 8'h03);
		ext_rst(1'b0);
		chk("pin pc", pcv, 13'h0000);
		rc(ADDR_STATUS, 8'h0d);
		rc(ADDR_PWR_STAT, 8'h0b);
		$display("test pin reset running done");
		axw(ADDR_OPTION, 8'h00);
		axw(ADDR_PERIOD, 8'h10);
		axw(ADDR_PORTB, 8'hff);
		axw(ADDR_STATUS, 8'he5);
		pulse(1);
		pulse(0);
		@(negedge clk_i);
		chk("wake hold out", wake_hold_o, 1);
		chk("core kept running", core_reset_o, 0);
		wait_rel();
		chk("crystal wake hold", inr(n, OSC2 - 4, OSC2 + 8), 1);
		chk("watchdog wake pc", pcv, 13'h0124);
		rc(ADDR_STATUS, 8'he5);
		rc(ADDR_PWR_STAT, 8'h0b);
		rc(ADDR_OPTION, 8'h00);
		rc(ADDR_PERIOD, 8'hff);
		rc(ADDR_PORTB, 8'hfc);
		$display("test watchdog wake done");
		axw(ADDR_CFG, 8'h16);
		for (int g = 0; g < 2; g++) begin
			axw(ADDR_IRQ, g ? 8'h80 : 8'h00);
			pc_i <= 13'h0456;
			pulse(1);
			pulse(2);
			wait_rel();
			chk("irq wake hold", inr(n, 1, 3), 1);
			chk("irq wake pc", pcv, g ? 13'h0004 : 13'h0457);
			rc(ADDR_STATUS, 8'hf5);
		end
		$display("test interrupt wake done");
		axw(ADDR_STATUS, 8'he7);
		pulse(1);
		ext_rst(1'b0);
		chk("pin sleep pc", pcv, 13'h0000);
		rc(ADDR_STATUS, 8'h17);
		$display("test pin reset asleep done");
		axw(ADDR_CFG, 8'h17);
		axw(ADDR_PWR_STAT, 8'h03);
		ext_rst(1'b1);
		chk("brown-out hold", inr(n, PW, PW + 12), 1);
		rc(ADDR_PWR_STAT, 8'h0a);
		rc(ADDR_STATUS, 8'h1f);
		$display("test brown-out done");
		// detection off: a low supply must not reset or touch the flags
		axw(ADDR_CFG, 8'h07);
		brownout_detect_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		chk("brown-out ignored", core_reset_o, 0);
		@(posedge clk_i);
		brownout_detect_i <= 1'b0;
		rc(ADDR_PWR_STAT, 8'h0a);
		rc(ADDR_STATUS, 8'h1f);
		$display("test brown-out disabled done");
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rc(ADDR_PWR_STAT, 8'h09);
		$display("test second power-on done");
		summarize();
	end
endmodule // test_reset_cause_and_timeout_control
`default_nettype wire
